// ==== logic/pld_params.svh ====
// How it works
// [R01] bit 14 picks preamble mode, resets short
// [R02] long mode needs seven preamble bytes
// [R03] short mode accepts preamble above three bytes
// [R04] preamble mode ignored at 100 Mbps
// [R05] software picks short mode for tiny preambles
// [R06] six-bit window length, code plus one ticks
// [R07] error window runs only in steady state
// [R08] bits 9-4 set errors needed for drop
// [R09] bits 5-0 set descrambler drop window
// [R10] bit 14 picks TDR listening channel
// [R11] bit 13 picks TDR transmit channel
// [R12] bit 12 keeps offset removal across runs
// [R13] bits 10-8 set averaged runs, power two
// [R14] bits 6-4 pick cable segment
// [R15] errors reaching count in window drop link
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

`define PLD_ADDR_TEN      9'h02A
`define PLD_ADDR_FLD1     9'h117
`define PLD_ADDR_FLD2     9'h131
`define PLD_ADDR_CDS      9'h170
`define PLD_ADDR_ISTAT    9'h1F0
`define PLD_ADDR_IMASK    9'h1F1

`define PLD_RST_TEN       16'h7998
`define PLD_RST_FLD1      16'h0000
`define PLD_RST_FLD2      16'h0000
`define PLD_RST_CDS       16'h0C12

`define PLD_WM_TEN        16'h7FFF
`define PLD_WM_FLD1       16'hFFF0
`define PLD_WM_FLD2       16'hFFFF
`define PLD_WM_CDS        16'h7FFF
`define PLD_WM_IRQ        4'hF

`define PLD_BIT_PRE       14
`define PLD_WIN_HI        15
`define PLD_WIN_LO        10
`define PLD_NUM_HI        9
`define PLD_NUM_LO        4
`define PLD_DSC_HI        5
`define PLD_DSC_LO        0
`define PLD_BIT_SAME      14
`define PLD_BIT_CHB       13
`define PLD_BIT_KEEP      12
`define PLD_AVG_HI        10
`define PLD_AVG_LO        8
`define PLD_SEG_HI        6
`define PLD_SEG_LO        4

`define PLD_LONG_MIN      4'h7
`define PLD_SHORT_MIN     4'h4
`define PLD_AVG_RSVD      3'h7
`define PLD_SEG_FIRST     3'h1
`define PLD_SEG_LAST      3'h5

`define PLD_EV_MLT        0
`define PLD_EV_DSC        1
`define PLD_EV_PRE        2
`define PLD_EV_TDR        3

`endif

// ==== logic/pld_pkg.sv ====
package pld_pkg;

    typedef enum logic [1:0] {
        PRE_IDLE,
        PRE_COUNT,
        PRE_DONE
    } pld_pre_state_t;

    typedef struct packed {
        logic       listen_same;
        logic       tx_chan_b;
        logic       keep_offset_removal_state;
        logic [6:0] avg_runs;
        logic [2:0] segment;
    } pld_tdr_cfg_t;

    typedef struct packed {
        logic [15:0]    ten_cfg;
        logic [15:0]    fld1;
        logic [15:0]    fld2;
        logic [15:0]    cds;
        logic [3:0]     irq_stat;
        logic [3:0]     irq_mask;
        logic [15:0]    rd_data;
        pld_pre_state_t pre_st;
        logic [3:0]     pre_cnt;
        logic           pre_ok;
        logic           pre_bad;
        logic [5:0]     win_cnt;
        logic [6:0]     err_cnt;
        logic [5:0]     dsc_cnt;
        logic           link_down;
        logic           tdr_go;
        logic           tdr_dc_rst;
    } pld_state_t;

endpackage

// ==== logic/pld_top.sv ====
`timescale 1ns/1ps
`include "pld_params.svh"

module pld_top #(
    parameter int AW = 9,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // register port
    input  wire logic [AW-1:0]    reg_addr,
    input  wire logic [DW-1:0]    reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [DW-1:0]    reg_rdata,
    // receive status from the phy core
    input  wire logic             speed_100,
    input  wire logic             rx_steady,
    input  wire logic             line_tick,
    input  wire logic             line_err,
    input  wire logic             dscr_err,
    // 10 Mbps preamble
    input  wire logic             rx10_pre_byte,
    input  wire logic             rx10_sfd,
    output logic                  rx10_accept,
    output logic                  rx10_reject,
    // link drop
    output logic                  link_down,
    // cable diagnostics
    input  wire logic             tdr_start,
    output logic                  tdr_go,
    output logic                  tdr_dc_reset,
    output pld_pkg::pld_tdr_cfg_t tdr_cfg,
    // interrupt
    output logic                  irq
);

    // refused at elaboration: the map needs nine index bits and 16-bit words
    if (AW < 9 || DW != 16) begin : g_bad_params
        $error("pld_top: needs AW >= 9 and DW == 16");
    end

    pld_pkg::pld_state_t st_ff;
    pld_pkg::pld_state_t nxt_st;

    logic [AW-1:0] addr_9;
    logic [5:0]    win_code;
    logic [5:0]    num_code;
    logic [5:0]    dsc_code;
    logic [2:0]    avg_code;
    logic [2:0]    seg_code;
    logic          long_mode;
    logic [6:0]    err_sum;
    logic [3:0]    ev_set;
    logic [3:0]    ev_clr;
    logic          win_end;
    logic          mlt_drop;
    logic          dsc_drop;
    logic          tdr_bad;

    assign addr_9    = reg_addr;
    assign long_mode = ~st_ff.ten_cfg[`PLD_BIT_PRE];
    assign win_code  = st_ff.fld1[`PLD_WIN_HI:`PLD_WIN_LO];
    assign num_code  = st_ff.fld1[`PLD_NUM_HI:`PLD_NUM_LO];
    assign dsc_code  = st_ff.fld2[`PLD_DSC_HI:`PLD_DSC_LO];
    assign avg_code  = st_ff.cds[`PLD_AVG_HI:`PLD_AVG_LO];
    assign seg_code  = st_ff.cds[`PLD_SEG_HI:`PLD_SEG_LO];

    // window of code+1 ticks ends when the tick counter hits the code
    assign win_end   = line_tick && (st_ff.win_cnt == win_code); // [R06]
    assign err_sum   = st_ff.err_cnt + {6'h00, line_tick & line_err};

    // reserved codes (zero) leave the detector disarmed
    assign mlt_drop  = speed_100 && rx_steady && (win_code != 6'h00)
                       && (num_code != 6'h00)
                       && (err_sum >= {1'b0, num_code}); // [R15] [R08]

    // descrambler errors on consecutive ticks filling the window
    assign dsc_drop  = speed_100 && rx_steady && (dsc_code != 6'h00)
                       && line_tick && dscr_err
                       && (st_ff.dsc_cnt + 6'h01 >= dsc_code); // [R09]

    assign tdr_bad   = (avg_code == `PLD_AVG_RSVD)
                       || (seg_code < `PLD_SEG_FIRST)
                       || (seg_code > `PLD_SEG_LAST); // [R13] [R14]

    assign ev_set = {tdr_start & tdr_bad,
                     st_ff.pre_bad,
                     dsc_drop & ~st_ff.link_down,
                     mlt_drop & ~st_ff.link_down};

    assign ev_clr = (reg_rd && addr_9 == `PLD_ADDR_ISTAT) ? 4'hF : 4'h0;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pre_ok     = 1'b0;
        nxt_st.pre_bad    = 1'b0;
        nxt_st.tdr_go     = 1'b0;
        nxt_st.tdr_dc_rst = 1'b0;

        // register writes; read-only bits stay zero through the masks
        if (reg_wr) begin
            case (addr_9)
                `PLD_ADDR_TEN: begin
                    nxt_st.ten_cfg = reg_wdata & `PLD_WM_TEN; // [R01]
                end
                `PLD_ADDR_FLD1: begin
                    nxt_st.fld1 = reg_wdata & `PLD_WM_FLD1;
                end
                `PLD_ADDR_FLD2: begin
                    nxt_st.fld2 = reg_wdata & `PLD_WM_FLD2;
                end
                `PLD_ADDR_CDS: begin
                    nxt_st.cds = reg_wdata & `PLD_WM_CDS;
                end
                `PLD_ADDR_IMASK: begin
                    nxt_st.irq_mask = reg_wdata[3:0] & `PLD_WM_IRQ;
                end
                default: begin
                    nxt_st.cds = st_ff.cds;
                end
            endcase
        end

        // read data valid the cycle after the strobe, zero when unmapped
        nxt_st.rd_data = 16'h0000;
        if (reg_rd) begin
            case (addr_9)
                `PLD_ADDR_TEN:   nxt_st.rd_data = st_ff.ten_cfg;
                `PLD_ADDR_FLD1:  nxt_st.rd_data = st_ff.fld1;
                `PLD_ADDR_FLD2:  nxt_st.rd_data = st_ff.fld2;
                `PLD_ADDR_CDS:   nxt_st.rd_data = st_ff.cds;
                `PLD_ADDR_ISTAT: nxt_st.rd_data = {12'h000, st_ff.irq_stat};
                `PLD_ADDR_IMASK: nxt_st.rd_data = {12'h000, st_ff.irq_mask};
                default:         nxt_st.rd_data = 16'h0000;
            endcase
        end

        // set wins over the clear of a status read
        nxt_st.irq_stat = (st_ff.irq_stat & ~ev_clr) | ev_set;

        // 10 Mbps preamble counting; mode has no say at 100 Mbps
        if (speed_100) begin
            nxt_st.pre_st  = pld_pkg::PRE_IDLE; // [R04]
            nxt_st.pre_cnt = 4'h0;
        end else begin
            case (st_ff.pre_st)
                pld_pkg::PRE_IDLE: begin
                    nxt_st.pre_cnt = 4'h0;
                    if (rx10_pre_byte) begin
                        nxt_st.pre_cnt = 4'h1;
                        nxt_st.pre_st  = pld_pkg::PRE_COUNT;
                    end
                end
                pld_pkg::PRE_COUNT: begin
                    // saturate so very long preambles never wrap
                    if (rx10_pre_byte && st_ff.pre_cnt != 4'hF) begin
                        nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
                    end
                    if (rx10_sfd) begin
                        nxt_st.pre_st = pld_pkg::PRE_DONE;
                        if (long_mode) begin
                            nxt_st.pre_ok  = (st_ff.pre_cnt >= `PLD_LONG_MIN); // [R02]
                        end else begin
                            nxt_st.pre_ok  = (st_ff.pre_cnt >= `PLD_SHORT_MIN); // [R03]
                        end
                        nxt_st.pre_bad = ~nxt_st.pre_ok;
                    end
                end
                pld_pkg::PRE_DONE: begin
                    // one idle cycle keeps the frame's bytes out of the next count
                    nxt_st.pre_st  = pld_pkg::PRE_IDLE;
                    nxt_st.pre_cnt = 4'h0;
                end
                default: begin
                    nxt_st.pre_st  = pld_pkg::PRE_IDLE;
                    nxt_st.pre_cnt = 4'h0;
                end
            endcase
        end

        // error window only counts while the receiver sits in steady state
        if (!(speed_100 && rx_steady)) begin
            nxt_st.win_cnt = 6'h00; // [R07]
            nxt_st.err_cnt = 7'h00;
            nxt_st.dsc_cnt = 6'h00;
        end else begin
            if (win_end) begin
                nxt_st.win_cnt = 6'h00;
                nxt_st.err_cnt = 7'h00; // [R15]
            end else if (line_tick) begin
                nxt_st.win_cnt = st_ff.win_cnt + 6'h01; // [R06]
                nxt_st.err_cnt = err_sum;
            end
            if (line_tick) begin
                if (dscr_err && !dsc_drop) begin
                    nxt_st.dsc_cnt = st_ff.dsc_cnt + 6'h01;
                end else begin
                    nxt_st.dsc_cnt = 6'h00;
                end
            end
        end

        // link stays down until the receiver leaves steady state
        if (mlt_drop || dsc_drop) begin
            nxt_st.link_down = 1'b1; // [R15]
        end else if (!rx_steady) begin
            nxt_st.link_down = 1'b0;
        end

        // a run with reserved average or segment codes is refused
        if (tdr_start && !tdr_bad) begin
            nxt_st.tdr_go     = 1'b1;
            nxt_st.tdr_dc_rst = ~st_ff.cds[`PLD_BIT_KEEP]; // [R12]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{ten_cfg:   `PLD_RST_TEN,
                       fld1:      `PLD_RST_FLD1,
                       fld2:      `PLD_RST_FLD2,
                       cds:       `PLD_RST_CDS,
                       irq_stat:  4'h0,
                       irq_mask:  4'h0,
                       rd_data:   16'h0000,
                       pre_st:    pld_pkg::PRE_IDLE,
                       pre_cnt:   4'h0,
                       pre_ok:    1'b0,
                       pre_bad:   1'b0,
                       win_cnt:   6'h00,
                       err_cnt:   7'h00,
                       dsc_cnt:   6'h00,
                       link_down: 1'b0,
                       tdr_go:    1'b0,
                       tdr_dc_rst: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata    = st_ff.rd_data;
    assign rx10_accept  = st_ff.pre_ok;
    assign rx10_reject  = st_ff.pre_bad;
    assign link_down    = st_ff.link_down;
    assign tdr_go       = st_ff.tdr_go;
    assign tdr_dc_reset = st_ff.tdr_dc_rst;
    assign irq          = |(st_ff.irq_stat & st_ff.irq_mask);

    // one driver for the whole struct
    assign tdr_cfg = '{listen_same:               st_ff.cds[`PLD_BIT_SAME], // [R10]
                       tx_chan_b:                 st_ff.cds[`PLD_BIT_CHB], // [R11]
                       keep_offset_removal_state: st_ff.cds[`PLD_BIT_KEEP], // [R12]
                       avg_runs:                  7'h01 << avg_code, // [R13]
                       segment:                   seg_code}; // [R14]

endmodule // pld_top

// ==== testbench/pld_chk.sv ====
`timescale 1ns/1ps
module pld_chk #(
    parameter int DW = 16
) (
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    // watched ports
    input wire logic                  reg_rd,
    input wire logic [DW-1:0]         reg_rdata,
    input wire logic                  speed_100,
    input wire logic                  rx_steady,
    input wire logic                  line_tick,
    input wire logic                  rx10_sfd,
    input wire logic                  rx10_accept,
    input wire logic                  rx10_reject,
    input wire logic                  link_down,
    input wire logic                  tdr_start,
    input wire logic                  tdr_go,
    input wire logic                  tdr_dc_reset,
    input wire pld_pkg::pld_tdr_cfg_t tdr_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_drop_rise; !link_down ##1 link_down; endsequence
    sequence s_launch; tdr_start ##1 tdr_go; endsequence
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside slot");
    pre_speed_a: assert property ($past(speed_100) |-> !rx10_accept && !rx10_reject)
        else $error("preamble verdict at 100 Mbps");
    pre_cause_a: assert property ((rx10_accept || rx10_reject)
        |-> $past(rx10_sfd) && !(rx10_accept && rx10_reject)) else $error("preamble verdict without delimiter");
    pre_pulse_a: assert property (rx10_accept |=> !rx10_accept) else $error("accept longer than a pulse");
    drop_cause_a: assert property (s_drop_rise |-> $past(line_tick && rx_steady && speed_100))
        else $error("link drop without steady tick");
    drop_clear_a: assert property (!rx_steady |=> !link_down) else $error("link drop outside steady state");
    tdr_go_a: assert property (tdr_go |-> $past(tdr_start)) else $error("run launched unasked");
    tdr_refuse_a: assert property (tdr_start && (tdr_cfg.segment == 3'h0 || tdr_cfg.segment > 3'h5)
        |=> !tdr_go) else $error("run launched on reserved segment");
    dc_reset_a: assert property (s_launch |-> tdr_dc_reset == !$past(tdr_cfg.keep_offset_removal_state))
        else $error("offset removal reset wrong");
endmodule // pld_chk

bind pld_top pld_chk #(.DW(DW)) i_pld_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_100(speed_100),
    .rx_steady(rx_steady), .line_tick(line_tick), .rx10_sfd(rx10_sfd), .rx10_accept(rx10_accept),
    .rx10_reject(rx10_reject), .link_down(link_down), .tdr_start(tdr_start), .tdr_go(tdr_go),
    .tdr_dc_reset(tdr_dc_reset), .tdr_cfg(tdr_cfg));

// ==== testbench/pld_line_model.sv ====
`timescale 1ns/1ps
module pld_line_model (
    // clock
    input wire logic ref_clk,
    // toward the block
    output logic     line_tick,
    output logic     line_err,
    output logic     dscr_err,
    output logic     rx10_pre_byte,
    output logic     rx10_sfd
);
    initial begin
        {line_tick, line_err, dscr_err, rx10_pre_byte, rx10_sfd} = 5'h00;
    end
    task automatic tick(input logic e, input logic d);
        @(posedge ref_clk);
        line_tick <= 1'b1;
        line_err  <= e;
        dscr_err  <= d;
    endtask
    // error lines flip between ticks so unqualified errors would show
    task automatic quiet();
        @(posedge ref_clk);
        line_tick <= 1'b0;
        line_err  <= ~line_err;
        dscr_err  <= ~dscr_err;
    endtask
    task automatic frame(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            rx10_pre_byte <= 1'b1;
        end
        @(posedge ref_clk);
        rx10_pre_byte <= 1'b0;
        rx10_sfd      <= 1'b1;
        @(posedge ref_clk);
        rx10_sfd <= 1'b0;
    endtask
endmodule // pld_line_model

// ==== testbench/test_phy_link_drop_tdr_config.sv ====
`timescale 1ns/1ps
`include "pld_params.svh"
module test_phy_link_drop_tdr_config;
    logic                  ref_clk, rst_n, reg_wr, reg_rd, speed_100, rx_steady, tdr_start;
    logic                  line_tick, line_err, dscr_err, rx10_pre_byte, rx10_sfd;
    logic                  rx10_accept, rx10_reject, link_down, tdr_go, tdr_dc_reset, irq;
    logic [8:0]            reg_addr;
    logic [15:0]           reg_wdata, reg_rdata;
    pld_pkg::pld_tdr_cfg_t tdr_cfg;
    int                    errors = 0, n_checks = 0, cycles = 0;
    pld_top i_pld_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_100(speed_100), .rx_steady(rx_steady),
        .line_tick(line_tick), .line_err(line_err), .dscr_err(dscr_err), .rx10_pre_byte(rx10_pre_byte),
        .rx10_sfd(rx10_sfd), .rx10_accept(rx10_accept), .rx10_reject(rx10_reject), .link_down(link_down),
        .tdr_start(tdr_start), .tdr_go(tdr_go), .tdr_dc_reset(tdr_dc_reset), .tdr_cfg(tdr_cfg), .irq(irq));
    pld_line_model i_pld_line_model (.ref_clk(ref_clk), .line_tick(line_tick), .line_err(line_err),
        .dscr_err(dscr_err), .rx10_pre_byte(rx10_pre_byte), .rx10_sfd(rx10_sfd));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic t_regs();
        logic [8:0]  a [4];
        logic [15:0] r [4];
        logic [15:0] m [4];
        a = '{`PLD_ADDR_TEN, `PLD_ADDR_FLD1, `PLD_ADDR_FLD2, `PLD_ADDR_CDS};
        r = '{16'h7998, 16'h0000, 16'h0000, 16'h0C12};
        m = '{16'h7FFF, 16'hFFF0, 16'hFFFF, 16'h7FFF};
        foreach (a[i]) begin
            rd(a[i], r[i]);
            wr(a[i], 16'hFFFF);
            rd(a[i], m[i]);
            wr(a[i], r[i]);
        end
        rd(`PLD_ADDR_ISTAT, 16'h0000);
        wr(`PLD_ADDR_IMASK, 16'hFFFF);
        rd(`PLD_ADDR_IMASK, 16'h000F);
        wr(9'h1FF, 16'hFFFF);
        rd(9'h1FF, 16'h0000);
    endtask
    task automatic t_pre();
        int n [4];
        n = '{7, 6, 4, 3};
        wr(`PLD_ADDR_IMASK, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            // long mode first, then short mode as for partners with very short preambles
            wr(`PLD_ADDR_TEN, i < 2 ? 16'h3998 : 16'h7998);
            i_pld_line_model.frame(n[i]);
            #1 chk(16'({rx10_accept, rx10_reject}), i % 2 ? 16'h0001 : 16'h0002);
            @(posedge ref_clk);
            #1 chk(16'(irq), 16'(i % 2));
            rd(`PLD_ADDR_ISTAT, i % 2 ? 16'h0004 : 16'h0000);
        end
        speed_100 <= 1'b1;
        i_pld_line_model.frame(7);
        #1 chk(16'({rx10_accept, rx10_reject}), 16'h0000);
    endtask
    task automatic t_drop();
        wr(`PLD_ADDR_FLD1, 16'h0420);
        rx_steady <= 1'b0;
        repeat (2) i_pld_line_model.tick(1'b1, 1'b0);
        i_pld_line_model.quiet();
        #1 chk(16'(link_down), 16'h0000);
        rx_steady <= 1'b1;
        i_pld_line_model.tick(1'b0, 1'b0);
        i_pld_line_model.tick(1'b1, 1'b0);
        i_pld_line_model.tick(1'b1, 1'b0);
        i_pld_line_model.tick(1'b0, 1'b0);
        i_pld_line_model.quiet();
        #1 chk(16'(link_down), 16'h0000);
        repeat (2) i_pld_line_model.tick(1'b1, 1'b0);
        i_pld_line_model.quiet();
        #1 chk(16'(link_down), 16'h0001);
        rx_steady <= 1'b0;
        wr(`PLD_ADDR_FLD1, 16'h0000);
        wr(`PLD_ADDR_FLD2, 16'h0003);
        rx_steady <= 1'b1;
        i_pld_line_model.tick(1'b0, 1'b1);
        i_pld_line_model.tick(1'b0, 1'b1);
        i_pld_line_model.tick(1'b0, 1'b0);
        repeat (2) i_pld_line_model.tick(1'b0, 1'b1);
        i_pld_line_model.quiet();
        #1 chk(16'(link_down), 16'h0000);
        i_pld_line_model.tick(1'b0, 1'b1);
        i_pld_line_model.quiet();
        #1 chk(16'(link_down), 16'h0001);
        rx_steady <= 1'b0;
        rd(`PLD_ADDR_ISTAT, 16'h0003);
    endtask
    task automatic tdr(input logic [15:0] v, input logic [12:0] c, input logic [1:0] g, input logic k);
        wr(`PLD_ADDR_CDS, v);
        #1 if (k) chk(16'(tdr_cfg), {3'h0, c});
        @(posedge ref_clk);
        tdr_start <= 1'b1;
        @(posedge ref_clk);
        tdr_start <= 1'b0;
        #1 chk(16'({tdr_go, tdr_dc_reset}), 16'(g));
    endtask
    task automatic t_tdr();
        tdr(16'h0C12, 13'h0081, 2'b11, 1'b1);
        tdr(16'h7150, {3'h7, 7'h02, 3'h5}, 2'b10, 1'b1);
        for (int c = 0; c < 8; c++)
            tdr({5'h00, 3'(c), 8'h10}, {3'h0, 7'(1 << c), 3'h1}, c < 7 ? 2'b11 : 2'b00, c < 7);
        for (int s = 0; s < 8; s++)
            tdr({8'h04, 1'b0, 3'(s), 4'h0}, {3'h0, 7'h10, 3'(s)}, (s > 0 && s < 6) ? 2'b11 : 2'b00, 1'b1);
        rd(`PLD_ADDR_ISTAT, 16'h0008);
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, speed_100, rx_steady, tdr_start} = 6'h00;
        reg_addr  = 9'h000;
        reg_wdata = 16'h0000;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_pre();
        t_drop();
        t_tdr();
        test_done();
    end
endmodule // test_phy_link_drop_tdr_config
